// ### inc/usb_sie_ctrl_pkg.sv
package usb_sie_ctrl_pkg;

	// Register byte addresses on the plain register port.
	localparam logic [7:0] OFS_EP_SELECT  = 8'h22;
	localparam logic [7:0] OFS_ADDR_WAKE  = 8'h23;
	localparam logic [7:0] OFS_HALT       = 8'h24;
	localparam logic [7:0] OFS_SIG_STATUS = 8'h25;
	localparam logic [7:0] OFS_FIFO_CMD   = 8'h26;

	// Reset value of every register, and the answer to unmapped reads.
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Address and wake register layout.
	localparam int AW_WAKE_BIT = 0;
	localparam int AW_ADDR_LSB = 1;

	// Number of endpoints and widths of the select and halt fields.
	localparam int NUM_EP   = 4;
	localparam int EP_SEL_W = 3;
	localparam logic [1:0] EP_DMA = 2'h3;

	// Signal status register layout.
	localparam int SS_DEFER_BIT = 0;
	localparam int SS_ERR_BIT   = 1;
	localparam int SS_NAK_BIT   = 7;

	// FIFO command and status register layout.
	localparam int FC_REQ_BIT    = 0;
	localparam int FC_TX_BIT     = 1;
	localparam int FC_CLR_BIT    = 2;
	localparam int FC_DMAEN_BIT  = 3;
	localparam int FC_DMASEL_BIT = 4;
	localparam int FC_SETUP_BIT  = 5;
	localparam int FC_READY_BIT  = 6;
	localparam int FC_ZERO_LENGTH_FLAG_BIT   = 7;

	// Events from the serial interface engine core, same clock.
	typedef struct packed {
		logic       bus_reset;  // USB bus reset seen.
		logic       in_ack;     // Host acknowledged IN data.
		logic       ep0_err;    // Endpoint 0 FIFO access failed.
		logic       pkt_done;   // Host packet stored in a FIFO.
		logic       pkt_setup;  // That packet was a setup token.
		logic       pkt_zero;   // That packet had no data bytes.
		logic       in_token;   // IN token arrived.
		logic [1:0] in_ep;      // Endpoint addressed by the IN token.
		logic [3:0] fifo_ready; // Per-endpoint FIFO can be accessed.
		logic       ep3_full;   // Endpoint 3 FIFO is full.
	} sie_event_t;

	// One byte offered by a serial port data register.
	typedef struct packed {
		logic       valid; // Pulse: new byte in the data register.
		logic [7:0] data;  // The byte.
	} serial_feed_t;

	// FIFO control toward the engine core.
	typedef struct packed {
		logic       request;      // Level: firmware holds the FIFO.
		logic       write_dir;    // Level: firmware writes the FIFO.
		logic       clear;        // Pulse: empty the selected FIFO.
		logic       xfer_done;    // Pulse: firmware ended a transfer.
		logic [1:0] ep;           // Selected endpoint.
		logic       force_tx_err; // Pulse: answer the IN with underrun.
	} fifo_ctrl_t;

	// Serial DMA write into the endpoint 3 FIFO.
	typedef struct packed {
		logic       wr;   // Pulse: push data.
		logic [7:0] data; // Byte pushed.
	} dma_out_t;

	// Whole state of the control block.
	typedef struct packed {
		logic [7:0]          rdata;       // Read data, one cycle late.
		logic [EP_SEL_W-1:0] ep_sel;      // Endpoint select field.
		logic [7:0]          device_address_wakeup;         // Stored address and wake.
		logic [6:0]          active_addr; // Address the engine uses.
		logic [NUM_EP-1:0]   halt;        // Endpoint halt bits.
		logic                adr_defer;   // Deferred address mode.
		logic                ep0_err;     // Sticky endpoint 0 error.
		logic                nak_mask;    // NAK interrupt mask.
		logic                req;         // FIFO request.
		logic                tx;          // Direction and end mark.
		logic                clr;         // FIFO clear command.
		logic                dmaen;       // Serial DMA enable.
		logic                dmasel;      // Serial DMA source.
		logic                setup;       // Setup token flag.
		logic                ready;       // FIFO ready flag.
		logic                zero_length_flag;        // Zero-length flag.
		logic [NUM_EP-1:0]   underrun;    // FIFO emptied by a clear.
		fifo_ctrl_t          fc;          // FIFO control outputs.
		dma_out_t            dma;         // DMA outputs.
	} ctrl_state_t;

endpackage : usb_sie_ctrl_pkg

// ### design/usb_sie_fifo_address_control.sv
`timescale 1ns/10ps
module usb_sie_fifo_address_control (
	input  wire logic                           clk,
	input  wire logic                           reset_n,
	input  wire logic [7:0]                     addr,
	input  wire logic [7:0]                     wdata,
	input  wire logic                           wr_stb,
	input  wire logic                           rd_stb,
	output logic [7:0]                          rdata,
	input  wire usb_sie_ctrl_pkg::sie_event_t   ev,
	input  wire usb_sie_ctrl_pkg::serial_feed_t ser1,
	input  wire usb_sie_ctrl_pkg::serial_feed_t ser2,
	output logic [6:0]                          device_address,
	output logic                                remote_wake_en,
	output logic [3:0]                          halt_bits,
	output logic                                nak_mask,
	output usb_sie_ctrl_pkg::fifo_ctrl_t        fc,
	output usb_sie_ctrl_pkg::dma_out_t          dma
);
	import usb_sie_ctrl_pkg::*;

	// Reset synchroniser; only the second stage is read by the logic.
	logic [1:0]  rst_sync_r;
	logic        rst_n_s;
	ctrl_state_t st_r;
	ctrl_state_t st_nxt;

	// True when the select code names an endpoint that exists.
	function automatic logic ep_ok(input logic [EP_SEL_W-1:0] sel);
		ep_ok = (sel < EP_SEL_W'(NUM_EP));
	endfunction : ep_ok

	// Packs the FIFO command register from its fields.
	function automatic logic [7:0] fifo_cmd_byte(input ctrl_state_t s);
		logic [7:0] b;
		b = RST_BYTE;
		b[FC_REQ_BIT]    = s.req;
		b[FC_TX_BIT]     = s.tx;
		b[FC_CLR_BIT]    = s.clr;
		b[FC_DMAEN_BIT]  = s.dmaen;
		b[FC_DMASEL_BIT] = s.dmasel;
		b[FC_SETUP_BIT]  = s.setup;
		b[FC_READY_BIT]  = s.ready;
		b[FC_ZERO_LENGTH_FLAG_BIT]   = s.zero_length_flag;
		fifo_cmd_byte = b;
	endfunction : fifo_cmd_byte

	// The reset is released through two flip-flops so that its removal
	// never meets a clock edge halfway through the state registers.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n_s = rst_sync_r[1];

	// Next-state logic. Firmware writes are applied first and engine
	// events afterwards, so an event in the cycle of a clear wins.
	always_comb begin
		logic [7:0]   sig;
		serial_feed_t src;
		sig = RST_BYTE;
		src = ser1;
		st_nxt = st_r;
		// Pulses last one cycle unless raised again below.
		st_nxt.fc.clear        = 1'b0;
		st_nxt.fc.xfer_done    = 1'b0;
		st_nxt.fc.force_tx_err = 1'b0;
		st_nxt.dma.wr          = 1'b0;
		// Read data stand only in the cycle after the read strobe.
		st_nxt.rdata = RST_BYTE;
		if (rd_stb) begin
			sig[SS_DEFER_BIT] = st_r.adr_defer;
			sig[SS_ERR_BIT]   = st_r.ep0_err;
			sig[SS_NAK_BIT]   = st_r.nak_mask;
			case (addr)
				OFS_EP_SELECT: begin
					st_nxt.rdata = {5'h00, st_r.ep_sel};
				end
				OFS_ADDR_WAKE: begin
					st_nxt.rdata = st_r.device_address_wakeup;
				end
				OFS_HALT: begin
					// Upper four bits always read zero.
					st_nxt.rdata = {4'h0, st_r.halt};
				end
				OFS_SIG_STATUS: begin
					st_nxt.rdata = sig;
				end
				OFS_FIFO_CMD: begin
					st_nxt.rdata = fifo_cmd_byte(st_r);
				end
				default: begin
					// Unmapped addresses read zero.
					st_nxt.rdata = RST_BYTE;
				end
			endcase
		end
		// Firmware register writes.
		if (wr_stb) begin
			case (addr)
				OFS_EP_SELECT: begin
					st_nxt.ep_sel = wdata[EP_SEL_W-1:0];
				end
				OFS_ADDR_WAKE: begin
					st_nxt.device_address_wakeup = wdata;
					// Immediate mode: the engine takes the address now.
					if (!st_r.adr_defer) begin
						st_nxt.active_addr = wdata[7:AW_ADDR_LSB];
					end
				end
				OFS_HALT: begin
					st_nxt.halt = wdata[NUM_EP-1:0];
				end
				OFS_SIG_STATUS: begin
					st_nxt.adr_defer = wdata[SS_DEFER_BIT];
					st_nxt.nak_mask  = wdata[SS_NAK_BIT];
					// Writing zero clears the error; writing one keeps it.
					if (!wdata[SS_ERR_BIT]) begin
						st_nxt.ep0_err = 1'b0;
					end
				end
				OFS_FIFO_CMD: begin
					st_nxt.req    = wdata[FC_REQ_BIT];
					st_nxt.tx     = wdata[FC_TX_BIT];
					st_nxt.clr    = wdata[FC_CLR_BIT];
					st_nxt.dmasel = wdata[FC_DMASEL_BIT];
					st_nxt.setup  = wdata[FC_SETUP_BIT];
					st_nxt.zero_length_flag   = wdata[FC_ZERO_LENGTH_FLAG_BIT];
					// Disabling DMA is refused while endpoint 3 is full,
					// so no byte can be stranded between port and FIFO.
					if (wdata[FC_DMAEN_BIT] || !ev.ep3_full) begin
						st_nxt.dmaen = wdata[FC_DMAEN_BIT];
					end
					// A rising clear bit empties the selected FIFO even
					// when it is not ready, and arms the underrun answer.
					if (wdata[FC_CLR_BIT] && !st_r.clr && ep_ok(st_r.ep_sel)) begin
						st_nxt.fc.clear = 1'b1;
						st_nxt.underrun[st_r.ep_sel[1:0]] = 1'b1;
					end
					// Transfer end: a write ends on TX falling, a read on
					// TX rising, both with the request still held.
					if (st_r.req && wdata[FC_REQ_BIT]) begin
						if (st_r.tx && !wdata[FC_TX_BIT]) begin
							st_nxt.fc.xfer_done = 1'b1;
							st_nxt.underrun[st_r.ep_sel[1:0]] = 1'b0;
						end else if (!st_r.tx && wdata[FC_TX_BIT]) begin
							st_nxt.fc.xfer_done = 1'b1;
						end
					end
				end
				default: begin
					// Writes to unmapped addresses are ignored.
					st_nxt.ep_sel = st_r.ep_sel;
				end
			endcase
		end
		// Deferred mode: adopt the stored address once the host has read
		// the status stage, which by then follows the completed setup.
		if (ev.in_ack && st_r.adr_defer) begin
			st_nxt.active_addr = st_nxt.device_address_wakeup[7:AW_ADDR_LSB];
			st_nxt.adr_defer   = 1'b0;
		end
		// Engine events set their flags after any firmware clear.
		if (ev.ep0_err) begin
			st_nxt.ep0_err = 1'b1;
		end
		if (ev.pkt_done) begin
			st_nxt.setup = ev.pkt_setup;
			st_nxt.zero_length_flag  = ev.pkt_zero;
		end
		if (ev.in_token && st_r.underrun[ev.in_ep]) begin
			st_nxt.fc.force_tx_err = 1'b1;
		end
		// Ready only for a held request on an existing endpoint.
		st_nxt.ready = st_r.req && ep_ok(st_r.ep_sel) &&
		               ev.fifo_ready[st_r.ep_sel[1:0]];
		// Serial DMA moves each new byte of the port picked by dmasel straight into endpoint 3; a byte that arrives while it is full is dropped.
		src = st_r.dmasel ? ser2 : ser1;
		if (st_r.dmaen && src.valid && !ev.ep3_full) begin
			st_nxt.dma.wr   = 1'b1;
			st_nxt.dma.data = src.data;
		end
		// Bus reset clears halts and the FIFO command register.
		if (ev.bus_reset) begin
			st_nxt.halt   = '0;
			st_nxt.req    = 1'b0;
			st_nxt.tx     = 1'b0;
			st_nxt.clr    = 1'b0;
			st_nxt.dmaen  = 1'b0;
			st_nxt.dmasel = 1'b0;
			st_nxt.setup  = 1'b0;
			st_nxt.ready  = 1'b0;
			st_nxt.zero_length_flag   = 1'b0;
		end
		// Control outputs follow the register fields.
		st_nxt.fc.request   = st_nxt.req && ep_ok(st_nxt.ep_sel);
		st_nxt.fc.write_dir = st_nxt.tx;
		st_nxt.fc.ep        = st_nxt.ep_sel[1:0];
	end

	// State register; every field comes out of reset as zero.
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs come straight from the state flip-flops.
	assign rdata          = st_r.rdata;
	assign device_address = st_r.active_addr;
	assign remote_wake_en = st_r.device_address_wakeup[AW_WAKE_BIT];
	assign halt_bits      = st_r.halt;
	assign nak_mask       = st_r.nak_mask;
	assign fc             = st_r.fc;
	assign dma            = st_r.dma;

	// Helper terms for the checks, so that history is taken of plain
	// signals rather than of expressions.
	logic status_wr; // Firmware writes the signal status register.
	logic sel_valid; // Endpoint select names an existing endpoint.
	assign status_wr = wr_stb && (addr == OFS_SIG_STATUS);
	assign sel_valid = ep_ok(st_r.ep_sel);

	// Checks beside the logic they guard.
	reset_zero_a: assert property (
		@(posedge clk) $rose(rst_n_s) |->
		(st_r.device_address_wakeup == RST_BYTE) && (device_address == 7'h00))
		else $error("address register not zero after reset");

	defer_adopt_a: assert property (
		@(posedge clk) disable iff (!rst_n_s)
		(ev.in_ack && st_r.adr_defer && !wr_stb) |=>
		(device_address == st_r.device_address_wakeup[7:AW_ADDR_LSB]) && !st_r.adr_defer)
		else $error("deferred address not adopted after IN");

	defer_hold_a: assert property (
		@(posedge clk) disable iff (!rst_n_s)
		(st_r.adr_defer && !ev.in_ack) |=> $stable(device_address))
		else $error("deferred address changed without IN");

	immed_addr_a: assert property (
		@(posedge clk) disable iff (!rst_n_s)
		(wr_stb && addr == OFS_ADDR_WAKE && !st_r.adr_defer) |=>
		(device_address == st_r.device_address_wakeup[7:AW_ADDR_LSB]))
		else $error("immediate address not taken");

	halt_reset_a: assert property (
		@(posedge clk) disable iff (!rst_n_s)
		ev.bus_reset |=> (halt_bits == 4'h0))
		else $error("halt bits survive bus reset");

	cmd_reset_a: assert property (
		@(posedge clk) disable iff (!rst_n_s)
		ev.bus_reset |=> (fifo_cmd_byte(st_r) == RST_BYTE) && !fc.request)
		else $error("command register survives bus reset");

	err_sticky_a: assert property (
		@(posedge clk) disable iff (!rst_n_s)
		ev.ep0_err |=> st_r.ep0_err ##1
		(st_r.ep0_err || $past(status_wr)))
		else $error("error flag lost");

	underrun_tx_a: assert property (
		@(posedge clk) disable iff (!rst_n_s)
		fc.clear ##1 (ev.in_token && ev.in_ep == $past(fc.ep) &&
		!fc.xfer_done) |=> fc.force_tx_err)
		else $error("IN after clear not forced to underrun");

	dma_push_a: assert property (
		@(posedge clk) disable iff (!rst_n_s)
		dma.wr |-> $past(st_r.dmaen) && !$past(ev.ep3_full))
		else $error("DMA push while disabled or full");

	ready_flag_a: assert property (
		@(posedge clk) disable iff (!rst_n_s)
		st_r.ready |-> $past(st_r.req) && $past(sel_valid))
		else $error("ready without request");

	halt_read_a: assert property (
		@(posedge clk) disable iff (!rst_n_s)
		(rd_stb && addr == OFS_HALT) |=> (rdata[7:4] == 4'h0) &&
		(rdata[3:0] == $past(st_r.halt)))
		else $error("halt register read wrong");

endmodule : usb_sie_fifo_address_control

// ### bench/sie_host_model.sv
`timescale 1ns/10ps
// Stand-in for the engine core and the USB host behind it.
module sie_host_model #(
	parameter int EP3_DEPTH = 2 // Short endpoint 3 FIFO so full comes fast.
) (
	input  wire logic                         clk,
	input  wire usb_sie_ctrl_pkg::fifo_ctrl_t fc,
	input  wire usb_sie_ctrl_pkg::dma_out_t   dma,
	output usb_sie_ctrl_pkg::sie_event_t      ev
);
	import usb_sie_ctrl_pkg::*;

	sie_event_t pend = '0;    // One-cycle events asked for by the bench.
	logic [3:0] rdy  = 4'hF;  // FIFO ready levels, bench may lower them.
	int         fill = 0;     // Bytes held in the endpoint 3 FIFO.

	// Count DMA pushes; a clear of endpoint 3 empties it again.
	always @(posedge clk) begin
		if (fc.clear && fc.ep == EP_DMA) begin
			fill <= 0;
		end else if (dma.wr && fill < EP3_DEPTH) begin
			fill <= fill + 1;
		end
	end

	// Levels ride beside the pulses; the bench sets rdy, and the full flag comes from fill.
	always_comb begin
		ev            = pend;
		ev.fifo_ready = rdy;
		ev.ep3_full   = (fill >= EP3_DEPTH);
	end

	// Raise the given events for exactly one cycle.
	task automatic fire(input sie_event_t e);
		@(posedge clk);
		pend <= e;
		@(posedge clk);
		pend <= '0;
	endtask : fire
endmodule : sie_host_model

// ### bench/tb_usb_sie_fifo_address_control.sv
`timescale 1ns/10ps
// Register-level bench: firmware sequences with expected values.
module tb_usb_sie_fifo_address_control;
	import usb_sie_ctrl_pkg::*;

	logic         clk;             // 125 MHz clock.
	logic         reset_n;         // Active-low reset.
	logic         wr_stb;          // Write strobe.
	logic         rd_stb;          // Read strobe.
	logic [7:0]   addr;            // Register address.
	logic [7:0]   wdata;           // Write data.
	logic [7:0]   rdata;           // Read data.
	serial_feed_t ser1;            // First serial port.
	serial_feed_t ser2;            // Second serial port.
	sie_event_t   ev;              // Engine events from the model.
	logic [6:0]   device_address;  // Address in use.
	logic         remote_wake_en;  // Wake enable.
	logic [3:0]   halt_bits;       // Halt bits.
	logic         nak_mask;        // NAK mask.
	fifo_ctrl_t   fc;              // FIFO control.
	dma_out_t     dma;             // DMA push.
	sie_event_t   e;               // Scratch event.
	int           fail_count = 0;  // Mismatches.
	int           checks     = 0;  // Comparisons.

	usb_sie_fifo_address_control usb_sie_fifo_address_control_i (
		.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ev(ev),
		.ser1(ser1), .ser2(ser2), .device_address(device_address),
		.remote_wake_en(remote_wake_en), .halt_bits(halt_bits),
		.nak_mask(nak_mask), .fc(fc), .dma(dma)
	);

	sie_host_model #(.EP3_DEPTH(2)) sie_host_model_i (
		.clk(clk), .fc(fc), .dma(dma), .ev(ev)
	);

	// Free-running clock.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Print the verdict and stop.
	task automatic end_of_test();
		if (fail_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test

	// Compare one byte with case inequality so unknowns fail.
	task automatic chk(input string n, input logic [7:0] ex, got);
		checks++;
		if (got !== ex) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, ex, got);
		end
	endtask : chk

	// One-cycle write; effect is settled when the task returns.
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		addr   <= a;
		wdata  <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
		#1;
	endtask : wr

	// One-cycle read; data is looked at in the following cycle only.
	task automatic rd(input logic [7:0] a, ex, input string n);
		@(posedge clk);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1;
		chk(n, ex, rdata);
	endtask : rd

	// Events last one cycle; outputs are sampled once they have landed.
	task automatic pulse(input sie_event_t x);
		sie_host_model_i.fire(x);
		#1;
	endtask : pulse

	// One byte from a serial port, on the second port when two is set.
	task automatic feed(input logic two, input logic [7:0] d);
		@(posedge clk);
		if (two) begin
			ser2 <= '{1'b1, d};
		end else begin
			ser1 <= '{1'b1, d};
		end
		@(posedge clk);
		ser1.valid <= 1'b0;
		ser2.valid <= 1'b0;
		#1;
	endtask : feed

	// A hang counts as a mismatch and still reaches the verdict.
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		end_of_test();
	end

	// Main sequence.
	initial begin
		reset_n = 1'b0;
		addr    = 8'h00;
		wdata   = 8'h00;
		wr_stb  = 1'b0;
		rd_stb  = 1'b0;
		ser1    = '0;
		ser2    = '0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		for (int a = 8'h22; a <= 8'h26; a++) begin
			rd(8'(a), 8'h00, "reset_value");
		end
		rd(8'h30, 8'h00, "unmapped");
		chk("dev_addr", 8'h00, {1'b0, device_address});
		// Immediate address adoption with wake enabled.
		wr(OFS_ADDR_WAKE, 8'h0B);
		chk("dev_addr", 8'h05, {1'b0, device_address});
		chk("wake", 8'h01, {7'h00, remote_wake_en});
		rd(OFS_ADDR_WAKE, 8'h0B, "addr_wake");
		// Deferred address waits for the IN acknowledge.
		wr(OFS_SIG_STATUS, 8'h01);
		wr(OFS_ADDR_WAKE, 8'h10);
		chk("dev_addr", 8'h05, {1'b0, device_address});
		e = '0;
		e.in_ack = 1'b1;
		pulse(e);
		chk("dev_addr", 8'h08, {1'b0, device_address});
		rd(OFS_SIG_STATUS, 8'h00, "sig_status");
		// Halt bits and bus reset.
		wr(OFS_HALT, 8'hFF);
		rd(OFS_HALT, 8'h0F, "halt");
		wr(OFS_FIFO_CMD, 8'h12);
		e = '0;
		e.bus_reset = 1'b1;
		pulse(e);
		chk("halt_bits", 8'h00, {4'h0, halt_bits});
		rd(OFS_FIFO_CMD, 8'h00, "fifo_cmd");
		// Sticky error flag and NAK mask.
		e = '0;
		e.ep0_err = 1'b1;
		pulse(e);
		wr(OFS_SIG_STATUS, 8'h02);
		rd(OFS_SIG_STATUS, 8'h02, "sig_status");
		wr(OFS_SIG_STATUS, 8'h80);
		rd(OFS_SIG_STATUS, 8'h80, "sig_status");
		chk("nak_mask", 8'h01, {7'h00, nak_mask});
		// Clear endpoint 0, then an IN must underrun.
		wr(OFS_EP_SELECT, 8'h00);
		wr(OFS_FIFO_CMD, 8'h01);
		wr(OFS_FIFO_CMD, 8'h05);
		chk("clear", 8'h01, {7'h00, fc.clear});
		e = '0;
		e.in_token = 1'b1;
		pulse(e);
		chk("force_tx_err", 8'h01, {7'h00, fc.force_tx_err});
		wr(OFS_FIFO_CMD, 8'h00);
		// Ready follows the request and the FIFO state.
		wr(OFS_FIFO_CMD, 8'h01);
		rd(OFS_FIFO_CMD, 8'h41, "fifo_cmd");
		wr(OFS_FIFO_CMD, 8'h03);
		chk("xfer_done", 8'h01, {7'h00, fc.xfer_done});
		wr(OFS_FIFO_CMD, 8'h02);
		@(posedge clk);
		sie_host_model_i.rdy <= 4'hE;
		wr(OFS_FIFO_CMD, 8'h01);
		rd(OFS_FIFO_CMD, 8'h01, "fifo_cmd");
		wr(OFS_FIFO_CMD, 8'h00);
		@(posedge clk);
		sie_host_model_i.rdy <= 4'hF;
		// Reserved select code gets no request and no ready.
		wr(OFS_EP_SELECT, 8'h04);
		wr(OFS_FIFO_CMD, 8'h01);
		chk("request", 8'h00, {7'h00, fc.request});
		rd(OFS_FIFO_CMD, 8'h01, "fifo_cmd");
		wr(OFS_FIFO_CMD, 8'h00);
		wr(OFS_EP_SELECT, 8'h00);
		// Write transfer ends when direction drops under request.
		wr(OFS_FIFO_CMD, 8'h02);
		wr(OFS_FIFO_CMD, 8'h03);
		chk("write_dir", 8'h01, {7'h00, fc.write_dir});
		chk("request", 8'h01, {7'h00, fc.request});
		rd(OFS_FIFO_CMD, 8'h43, "fifo_cmd");
		wr(OFS_FIFO_CMD, 8'h01);
		chk("xfer_done", 8'h01, {7'h00, fc.xfer_done});
		wr(OFS_FIFO_CMD, 8'h00);
		// The finished write refills endpoint 0, so no underrun now.
		e = '0;
		e.in_token = 1'b1;
		pulse(e);
		chk("force_tx_err", 8'h00, {7'h00, fc.force_tx_err});
		// Setup and zero-length packet flags.
		e = '0;
		e.pkt_done  = 1'b1;
		e.pkt_setup = 1'b1;
		pulse(e);
		rd(OFS_FIFO_CMD, 8'h20, "fifo_cmd");
		e.pkt_setup = 1'b0;
		e.pkt_zero  = 1'b1;
		pulse(e);
		rd(OFS_FIFO_CMD, 8'h80, "fifo_cmd");
		// Serial DMA from each source, then the full-FIFO refusal.
		wr(OFS_FIFO_CMD, 8'h08);
		feed(1'b0, 8'hA5);
		chk("dma_wr", 8'h01, {7'h00, dma.wr});
		chk("dma_data", 8'hA5, dma.data);
		feed(1'b1, 8'h3C);
		chk("dma_wr", 8'h00, {7'h00, dma.wr});
		wr(OFS_FIFO_CMD, 8'h18);
		feed(1'b1, 8'h3C);
		chk("dma_data", 8'h3C, dma.data);
		wr(OFS_FIFO_CMD, 8'h10);
		rd(OFS_FIFO_CMD, 8'h18, "fifo_cmd");
		wr(OFS_EP_SELECT, 8'h03);
		chk("ep", 8'h03, {6'h00, fc.ep});
		wr(OFS_FIFO_CMD, 8'h1D);
		wr(OFS_FIFO_CMD, 8'h10);
		rd(OFS_FIFO_CMD, 8'h10, "fifo_cmd");
		end_of_test();
	end
endmodule : tb_usb_sie_fifo_address_control
